/* ubt_pkg.sv */
// constants, field positions, enumerations and helpers of the serial core
// assumes an apb slave with byte addresses in the low eight bits
// Functional notes
// RQ1: baud register is divisor times 64; six low bits form a fraction
// RQ2: software keeps baud between 64 and 65535
// RQ3: synchronous mode uses only baud bits 15..6; fraction written zero
// RQ4: samples per bit are 16 normal, 8 double speed, 2 synchronous
// RQ5: rate generator clocks shifting unless the transfer clock pin is chosen
// RQ6: written data goes to transmit buffer, then shift register, then out
// RQ7: transmit complete set when frame done and nothing else pending
// RQ8: software writes transmit data only while data-empty flag is set
// RQ9: unused upper bits of short characters are ignored on transmit
// RQ10: nine-bit writes follow the selected byte order
// RQ11: transmitter disable waits until shifter, data and buffer are empty
// RQ12: disabled transmitter releases the pin and makes it an input
// RQ13: receiver starts on valid start bit, ignores any second stop bit
// RQ14: first stop bit moves frame to buffer and sets receive complete
// RQ15: receive buffer holds two frames, oldest shown with its status
// RQ16: nine-bit low-first advances on high byte read, else on low byte
// RQ17: software reads the non-advancing byte first
// RQ18: frame, overflow and parity errors stay with their frame
// RQ19: overflow flagged when a frame arrives into a full buffer
// RQ20: parity enabled: received parity checked, mismatch flagged
// RQ21: receiver disable flushes buffer and drops the frame in progress
// RQ22: software empties buffer by reading until receive complete clears
// RQ23: frame is start, 5 to 9 data, optional parity, 1 or 2 stops
// RQ24: first stop bit sampled low sets the frame error flag
package ubt_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_RX_LOW = 8'h00;
    localparam logic [7:0] OFS_RX_HIGH = 8'h04;
    localparam logic [7:0] OFS_TX_LOW = 8'h08;
    localparam logic [7:0] OFS_TX_HIGH = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_CTRL = 8'h14;
    localparam logic [7:0] OFS_FRAME = 8'h18;
    localparam logic [7:0] OFS_BAUD = 8'h1c;
    // field positions
    localparam int STAT_RXC = 7;
    localparam int STAT_TXC = 6;
    localparam int STAT_DRE = 5;
    localparam int CTRL_RXEN = 0;
    localparam int CTRL_TXEN = 1;
    localparam int CTRL_EXTCLK = 2;
    localparam int FC_STOP2 = 3;
    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] FRAME_RST = 8'h03;
    localparam logic [15:0] BAUD_RST = 16'h0040;
    // fractional generator
    localparam int FRAC_BITS = 6;
    localparam logic [16:0] FRAC_STEP = 17'h00040;
    // samples per bit
    localparam logic [4:0] SAMP_NORMAL = 5'h10;
    localparam logic [4:0] SAMP_DOUBLE = 5'h08;
    localparam logic [4:0] SAMP_SYNC = 5'h02;

    typedef enum logic [2:0] {
        CS_5 = 3'b000, CS_6 = 3'b001, CS_7 = 3'b010, CS_8 = 3'b011,
        CS_9L = 3'b110, CS_9H = 3'b111
    } ubt_char_size_e;
    typedef enum logic [1:0] {
        MODE_ASYNC = 2'b00, MODE_DOUBLE = 2'b01, MODE_SYNC = 2'b10
    } ubt_mode_e;
    typedef enum logic [1:0] {
        PAR_NONE = 2'b00, PAR_EVEN = 2'b10, PAR_ODD = 2'b11
    } ubt_par_e;

    // data bits per character
    function automatic logic [3:0] char_bits(input logic [2:0] cs);
        case (cs)
            3'b000: char_bits = 4'h5;
            3'b001: char_bits = 4'h6;
            3'b010: char_bits = 4'h7;
            3'b110, 3'b111: char_bits = 4'h9;
            default: char_bits = 4'h8;
        endcase
    endfunction

    // samples per bit for a mode; an external clock gives two edges per bit
    function automatic logic [4:0] samples_per_bit(input logic [1:0] md, input logic ext);
        if (ext || md == MODE_SYNC) begin
            samples_per_bit = SAMP_SYNC;
        end else if (md == MODE_DOUBLE) begin
            samples_per_bit = SAMP_DOUBLE;
        end else begin
            samples_per_bit = SAMP_NORMAL;
        end
    endfunction

    // keep only the bits of the character
    function automatic logic [8:0] char_mask(input logic [8:0] d, input logic [3:0] n);
        char_mask = d & 9'(9'h1ff >> (4'h9 - n));
    endfunction

    // parity bit for even or odd parity
    function automatic logic frame_parity(input logic [8:0] d, input logic [3:0] n,
                                          input logic odd);
        frame_parity = (^char_mask(d, n)) ^ odd;
    endfunction
endpackage

/* ubt_baud_gen.sv */
// fractional sample tick generator
// assumes ext_clk_sync is already synchronised to pclk
`timescale 1ns/1ps
module ubt_baud_gen (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [15:0] baud,
    input wire logic sync_mode,
    input wire logic ext_clk_sel,
    input wire logic ext_clk_sync,
    output logic sample_tick
);
    logic [16:0] acc;
    logic [16:0] div;
    logic [16:0] next_acc;
    logic ext_clk_prev;

    // divisor: fraction dropped in synchronous mode, floor of one whole step
    always_comb begin
        div = {1'b0, baud};
        if (sync_mode) begin
            div = {1'b0, baud[15:6], 6'h00}; // see RQ3
        end
        if (div < ubt_pkg::FRAC_STEP) begin
            div = ubt_pkg::FRAC_STEP;
        end
        next_acc = acc + ubt_pkg::FRAC_STEP;
    end

    // add 64 per clock, tick and wrap when the divisor is reached
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc <= 17'h00000;
            ext_clk_prev <= 1'b0;
            sample_tick <= 1'b0;
        end else begin
            ext_clk_prev <= ext_clk_sync;
            if (ext_clk_sel) begin
                acc <= 17'h00000;
                sample_tick <= ext_clk_sync != ext_clk_prev;
            end else if (next_acc >= div) begin
                acc <= next_acc - div; // see RQ1
                sample_tick <= 1'b1; // see RQ5
            end else begin
                acc <= next_acc;
                sample_tick <= 1'b0;
            end
        end
    end
endmodule

/* ubt_core.sv */
// serial transmitter/receiver core with apb register access
// assumes pclk at 20 mhz, rxd and transfer clock from pins, apb master
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module ubt_core (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rxd,
    input wire logic transfer_clock_pin,
    output logic txd_out,
    output logic txd_oe_n
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000, ST_START = 3'b001, ST_DATA = 3'b010,
        ST_PARITY = 3'b011, ST_STOP1 = 3'b100, ST_STOP2 = 3'b101
    } ubt_state_e;

    logic [7:0] ctrl;
    logic [7:0] fctl;
    logic [15:0] baud;
    logic rxd_meta, rxd_s, ext_clk_meta, ext_clk_s;
    logic sample_tick;
    ubt_pkg::ubt_char_size_e cs;
    logic [3:0] nbits;
    logic [4:0] spb;
    logic par_en, par_odd, nine_bit_low_first;
    logic setup, wr_done, rd_done, pop_armed, pop;
    logic [31:0] rd_mux;
    logic [8:0] tx_dat, tx_buf, tx_sh;
    logic tx_dat_full, tx_buf_full, tx_on, next_tx_on, tx_busy, tx_load, tx_done;
    logic tx_par, transmit_complete_flag, tx_data_empty_flag;
    ubt_state_e tx_st, rx_st;
    logic [3:0] tx_bitn, rx_bitn;
    logic [4:0] tx_samp, rx_samp;
    logic [8:0] rx_sh;
    logic rx_par_err, rx_push, receive_complete_flag;
    logic [1:0] rx_cnt;
    logic [8:0] rx_data [0:1];
    logic [2:0] rx_err [0:1]; // overflow, frame error, parity error

    // frame format decode
    always_comb begin
        cs = ubt_pkg::ubt_char_size_e'(fctl[2:0]);
        nbits = ubt_pkg::char_bits(fctl[2:0]);
        spb = ubt_pkg::samples_per_bit(fctl[7:6], ctrl[ubt_pkg::CTRL_EXTCLK]); // see RQ4
        par_en = fctl[5];
        par_odd = fctl[4];
        nine_bit_low_first = cs == ubt_pkg::CS_9L;
    end

    // two-stage synchronisers for the pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxd_meta <= 1'b1;
            rxd_s <= 1'b1;
            ext_clk_meta <= 1'b0;
            ext_clk_s <= 1'b0;
        end else begin
            rxd_meta <= rxd;
            rxd_s <= rxd_meta;
            ext_clk_meta <= transfer_clock_pin;
            ext_clk_s <= ext_clk_meta;
        end
    end

    ubt_baud_gen ubt_baud_gen_i (
        .pclk(pclk),
        .presetn(presetn),
        .baud(baud),
        .sync_mode(fctl[7:6] == ubt_pkg::MODE_SYNC),
        .ext_clk_sel(ctrl[ubt_pkg::CTRL_EXTCLK]),
        .ext_clk_sync(ext_clk_s),
        .sample_tick(sample_tick)
    );

    // apb phases
    assign setup = psel && !penable;
    assign wr_done = psel && penable && pready && pwrite;
    assign rd_done = psel && penable && pready && !pwrite;
    assign pop = rd_done && pop_armed;
    assign receive_complete_flag = rx_cnt != 2'b00;
    assign tx_data_empty_flag = !tx_dat_full;

    // read multiplexer, oldest frame shown
    always_comb begin
        rd_mux = 32'h00000000;
        if (paddr == ubt_pkg::OFS_RX_LOW) begin
            rd_mux[7:0] = receive_complete_flag ? rx_data[0][7:0] : 8'h00; // see RQ15
        end else if (paddr == ubt_pkg::OFS_RX_HIGH) begin
            if (receive_complete_flag) begin
                rd_mux[7:0] = {1'b1, rx_err[0][2], 3'b000, rx_err[0][1:0],
                               rx_data[0][8]}; // see RQ18
            end
        end else if (paddr == ubt_pkg::OFS_STATUS) begin
            rd_mux[7:0] = {receive_complete_flag, transmit_complete_flag,
                           tx_data_empty_flag, 5'h00};
        end else if (paddr == ubt_pkg::OFS_CTRL) begin
            rd_mux[7:0] = ctrl;
        end else if (paddr == ubt_pkg::OFS_FRAME) begin
            rd_mux[7:0] = fctl;
        end else if (paddr == ubt_pkg::OFS_BAUD) begin
            rd_mux[15:0] = baud;
        end
    end

    // apb answer: one wait-free access phase, registered data and error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            pop_armed <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= setup && (paddr[1:0] != 2'b00 || paddr > ubt_pkg::OFS_BAUD);
            prdata <= (setup && !pwrite) ? rd_mux : 32'h00000000;
            pop_armed <= setup && !pwrite && receive_complete_flag &&
                         paddr == (nine_bit_low_first ? ubt_pkg::OFS_RX_HIGH
                                                      : ubt_pkg::OFS_RX_LOW); // see RQ16
        end
    end

    // software control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= ubt_pkg::CTRL_RST;
            fctl <= ubt_pkg::FRAME_RST;
            baud <= ubt_pkg::BAUD_RST;
        end else if (wr_done) begin
            if (paddr == ubt_pkg::OFS_CTRL) begin
                ctrl <= {5'h00, pwdata[2:0]};
            end else if (paddr == ubt_pkg::OFS_FRAME) begin
                fctl <= pwdata[7:0];
            end else if (paddr == ubt_pkg::OFS_BAUD) begin
                baud <= pwdata[15:0];
            end
        end
    end

    // transmitter stays on until every stage has drained
    assign tx_busy = tx_st != ST_IDLE || tx_buf_full || tx_dat_full;
    assign next_tx_on = ctrl[ubt_pkg::CTRL_TXEN] || (tx_on && tx_busy); // see RQ11
    assign tx_load = tx_st == ST_IDLE && tx_buf_full && tx_on;
    assign tx_done = sample_tick && tx_samp == spb - 5'h01 &&
                     ((tx_st == ST_STOP1 && !fctl[ubt_pkg::FC_STOP2]) || tx_st == ST_STOP2);

    // data registers and transmit buffer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_dat <= 9'h000;
            tx_dat_full <= 1'b0;
            tx_buf <= 9'h000;
            tx_buf_full <= 1'b0;
        end else begin
            if (wr_done && ctrl[ubt_pkg::CTRL_TXEN] && !tx_dat_full) begin
                if (paddr == ubt_pkg::OFS_TX_LOW) begin
                    tx_dat[7:0] <= pwdata[7:0];
                    tx_dat_full <= !nine_bit_low_first; // see RQ10
                end else if (paddr == ubt_pkg::OFS_TX_HIGH) begin
                    tx_dat[8] <= pwdata[0];
                    tx_dat_full <= nine_bit_low_first;
                end
            end
            if (tx_load) begin
                tx_buf_full <= 1'b0;
            end else if (tx_dat_full && !tx_buf_full) begin
                tx_buf <= ubt_pkg::char_mask(tx_dat, nbits); // see RQ9
                tx_buf_full <= 1'b1; // see RQ6
                tx_dat_full <= 1'b0;
            end
        end
    end

    // transmit shifter and pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_st <= ST_IDLE;
            tx_sh <= 9'h000;
            tx_bitn <= 4'h0;
            tx_samp <= 5'h00;
            tx_par <= 1'b0;
            txd_out <= 1'b1;
        end else if (tx_load) begin
            tx_st <= ST_START; // see RQ6
            tx_sh <= tx_buf;
            tx_samp <= 5'h00;
            tx_par <= ubt_pkg::frame_parity(tx_buf, nbits, par_odd);
            txd_out <= 1'b0; // see RQ23
        end else if (tx_st != ST_IDLE && sample_tick) begin
            if (tx_samp == spb - 5'h01) begin
                tx_samp <= 5'h00;
                case (tx_st)
                    ST_START: begin
                        tx_st <= ST_DATA;
                        txd_out <= tx_sh[0];
                        tx_sh <= tx_sh >> 1;
                        tx_bitn <= nbits - 4'h1;
                    end
                    ST_DATA: begin
                        if (tx_bitn == 4'h0) begin
                            tx_st <= par_en ? ST_PARITY : ST_STOP1;
                            txd_out <= par_en ? tx_par : 1'b1;
                        end else begin
                            txd_out <= tx_sh[0];
                            tx_sh <= tx_sh >> 1;
                        end
                        tx_bitn <= tx_bitn - 4'h1;
                    end
                    ST_PARITY: begin
                        tx_st <= ST_STOP1;
                        txd_out <= 1'b1;
                    end
                    ST_STOP1: tx_st <= fctl[ubt_pkg::FC_STOP2] ? ST_STOP2 : ST_IDLE;
                    default: tx_st <= ST_IDLE;
                endcase
            end else begin
                tx_samp <= tx_samp + 5'h01;
            end
        end
    end

    // pin ownership and transmit complete flag, set beats clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_on <= 1'b0;
            txd_oe_n <= 1'b1;
            transmit_complete_flag <= 1'b0;
        end else begin
            tx_on <= next_tx_on;
            txd_oe_n <= !next_tx_on; // see RQ12
            if (tx_done && !tx_buf_full && !tx_dat_full) begin
                transmit_complete_flag <= 1'b1; // see RQ7
            end else if (wr_done && paddr == ubt_pkg::OFS_STATUS &&
                         pwdata[ubt_pkg::STAT_TXC]) begin
                transmit_complete_flag <= 1'b0;
            end
        end
    end

    // receive shifter
    assign rx_push = ctrl[ubt_pkg::CTRL_RXEN] && sample_tick && rx_st == ST_STOP1 &&
                     rx_samp == spb - 5'h01; // see RQ14
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_st <= ST_IDLE;
            rx_samp <= 5'h00;
            rx_bitn <= 4'h0;
            rx_sh <= 9'h000;
            rx_par_err <= 1'b0;
        end else if (!ctrl[ubt_pkg::CTRL_RXEN]) begin
            rx_st <= ST_IDLE; // see RQ21
        end else if (sample_tick) begin
            rx_samp <= rx_samp + 5'h01;
            case (rx_st)
                ST_IDLE: begin
                    if (!rxd_s) begin
                        rx_st <= ST_START;
                        rx_samp <= 5'h00;
                    end
                end
                ST_START: begin
                    if (rx_samp == (spb >> 1) - 5'h01) begin
                        rx_st <= rxd_s ? ST_IDLE : ST_DATA; // see RQ13
                        rx_samp <= 5'h00;
                        rx_bitn <= 4'h0;
                        rx_sh <= 9'h000;
                        rx_par_err <= 1'b0;
                    end
                end
                ST_DATA: begin
                    if (rx_samp == spb - 5'h01) begin
                        rx_samp <= 5'h00;
                        rx_sh[rx_bitn] <= rxd_s;
                        rx_bitn <= rx_bitn + 4'h1;
                        if (rx_bitn == nbits - 4'h1) begin
                            rx_st <= par_en ? ST_PARITY : ST_STOP1;
                        end
                    end
                end
                ST_PARITY: begin
                    if (rx_samp == spb - 5'h01) begin
                        rx_samp <= 5'h00;
                        rx_par_err <= rxd_s !=
                                      ubt_pkg::frame_parity(rx_sh, nbits, par_odd); // see RQ20
                        rx_st <= ST_STOP1;
                    end
                end
                default: begin
                    if (rx_samp == spb - 5'h01) begin
                        rx_st <= ST_IDLE; // see RQ13
                    end
                end
            endcase
        end
    end

    // two-frame receive buffer with overflow on the youngest entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_cnt <= 2'b00;
            rx_data[0] <= 9'h000;
            rx_data[1] <= 9'h000;
            rx_err[0] <= 3'b000;
            rx_err[1] <= 3'b000;
        end else if (!ctrl[ubt_pkg::CTRL_RXEN]) begin
            rx_cnt <= 2'b00; // see RQ21
        end else if (rx_push && (pop || rx_cnt == 2'b00)) begin
            if (rx_cnt == 2'b10) begin
                rx_data[0] <= rx_data[1];
                rx_err[0] <= rx_err[1];
                rx_data[1] <= rx_sh;
                rx_err[1] <= {1'b0, !rxd_s, rx_par_err};
            end else begin
                rx_data[0] <= rx_sh;
                rx_err[0] <= {1'b0, !rxd_s, rx_par_err}; // see RQ24
                rx_cnt <= 2'b01;
            end
        end else if (rx_push) begin
            rx_data[1] <= rx_sh; // see RQ15
            rx_err[1] <= {rx_cnt == 2'b10, !rxd_s, rx_par_err}; // see RQ19
            rx_cnt <= 2'b10;
        end else if (pop) begin
            rx_data[0] <= rx_data[1];
            rx_err[0] <= rx_err[1];
            rx_cnt <= rx_cnt - 2'b01;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_tx_hold;
        !ctrl[ubt_pkg::CTRL_TXEN] && tx_on && tx_busy |=> tx_on && !txd_oe_n;
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("transmitter released early"); // see RQ11
    property p_pin_free;
        !tx_on |-> txd_oe_n && txd_out;
    endproperty
    a_pin_free: assert property (p_pin_free) else $error("pin driven while off"); // see RQ12
    property p_load;
        tx_load |=> tx_st == ST_START && !txd_out ##1 !txd_out;
    endproperty
    a_load: assert property (p_load) else $error("frame did not start"); // see RQ6
    property p_txc;
        tx_done && !tx_buf_full && !tx_dat_full |=> transmit_complete_flag;
    endproperty
    a_txc: assert property (p_txc) else $error("transmit complete not set"); // see RQ7
    property p_mask5;
        tx_load && cs == ubt_pkg::CS_5 |=> tx_sh[8:5] == 4'h0;
    endproperty
    a_mask5: assert property (p_mask5) else $error("upper bits not dropped"); // see RQ9
    property p_push;
        rx_push && rx_cnt == 2'b00 |=> rx_cnt == 2'b01 && rx_data[0] == $past(rx_sh);
    endproperty
    a_push: assert property (p_push) else $error("frame not buffered"); // see RQ14
    property p_pop_addr;
        pop |-> paddr == (nine_bit_low_first ? ubt_pkg::OFS_RX_HIGH : ubt_pkg::OFS_RX_LOW);
    endproperty
    a_pop_addr: assert property (p_pop_addr) else $error("wrong byte advanced"); // see RQ16
    property p_ovf;
        rx_push && rx_cnt == 2'b10 && !pop |=> rx_err[1][2] && rx_cnt == 2'b10;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow missed"); // see RQ19
    property p_flush;
        !ctrl[ubt_pkg::CTRL_RXEN] |=> rx_cnt == 2'b00 && rx_st == ST_IDLE;
    endproperty
    a_flush: assert property (p_flush) else $error("receiver not flushed"); // see RQ21
    property p_frame_err;
        rx_push && !rxd_s && rx_cnt == 2'b00 |=> rx_err[0][1];
    endproperty
    a_frame_err: assert property (p_frame_err) else $error("frame error missed"); // see RQ24

    c_tx_frame: cover property (tx_done && !tx_busy);
    c_rx_ovf: cover property (rx_push && rx_cnt == 2'b10);
    c_false_start: cover property (rx_st == ST_START ##1 rx_st == ST_IDLE);
    c_pop: cover property (pop && rx_cnt == 2'b10);
endmodule

/* ubt_remote.sv */
// remote peer: sends frames on rxd, decodes frames seen on txd
// assumes 8 data bits, no parity, 16 pclk per bit (baud 0x0040)
`timescale 1ns/1ps
module ubt_remote (
    input wire logic pclk,
    input wire logic txd,
    output logic rxd,
    output logic [7:0] got,
    output logic got_valid
);
    initial begin
        rxd = 1'b1; // idle high
        got = 8'h00;
        got_valid = 1'b0;
    end
    // start low, data lsb first, one stop; a low stop makes a bad frame
    task automatic send(input logic [7:0] d, input logic stop);
        logic [9:0] f;
        f = {stop, d, 1'b0};
        for (int k = 0; k < 10; k++) begin
            @(posedge pclk) rxd <= f[k];
            repeat (15) @(posedge pclk);
        end
        @(posedge pclk) rxd <= 1'b1;
        repeat (31) @(posedge pclk);
    endtask
    // sample txd mid-bit; valid pulse only if the stop bit is high
    always begin
        @(negedge txd);
        repeat (8) @(posedge pclk);
        for (int i = 0; i < 8; i++) begin
            repeat (16) @(posedge pclk);
            got[i] = txd;
        end
        repeat (16) @(posedge pclk);
        got_valid = txd;
        @(posedge pclk) got_valid = 1'b0;
    end
endmodule

/* test_uart_baud_tx_rx_core.sv */
// testbench of the serial core: apb master, remote peer, frame compare
// assumes core defaults: 8 data bits, baud 0x0040
`timescale 1ns/1ps
module test_uart_baud_tx_rx_core;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic rxd, txd_out, txd_oe_n, got_valid;
    logic [7:0] paddr, got;
    logic [7:0] b [3];
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] exp_q [$];
    int mismatches, num_checks;

    ubt_core ubt_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxd(rxd), .transfer_clock_pin(1'b0), .txd_out(txd_out),
        .txd_oe_n(txd_oe_n));
    ubt_remote ubt_remote_i (.pclk(pclk), .txd(txd_oe_n ? 1'b1 : txd_out), .rxd(rxd),
        .got(got), .got_valid(got_valid)); // released pin idles high

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic check(input string what, input logic [31:0] e, input logic [31:0] s);
        num_checks++;
        if (s !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, e, s);
        end
    endtask

    // one apb transfer; data and error taken at the ready edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) mismatches++;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check("read data", e, rd);
    endtask

    // poll one status bit, bounded
    task automatic wait_set(input int k);
        int n;
        n = 0;
        do begin
            apb(1'b0, ubt_pkg::OFS_STATUS, 32'h0);
            n++;
        end while (rd[k] !== 1'b1 && n < 500);
        check("status flag", 32'h1, {31'h0, rd[k]});
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // each decoded frame against the oldest note
    always @(negedge pclk) begin
        if (got_valid === 1'b1) begin
            if (exp_q.size() == 0)
                check("extra frame", 32'h0, 32'h1);
            else
                check("tx frame", {24'h0, exp_q.pop_front()}, {24'h0, got});
        end
    end

    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        results();
    end

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        presetn = 1'b0;
        void'($urandom(32'hb00987be));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(ubt_pkg::OFS_FRAME, 32'h3);
        rdchk(ubt_pkg::OFS_BAUD, 32'h40);
        rdchk(ubt_pkg::OFS_STATUS, 32'h20);
        rdchk(8'h20, 32'h0);
        check("slave error", 32'h1, {31'h0, err});
        apb(1'b1, ubt_pkg::OFS_CTRL, 32'h3);
        apb(1'b1, ubt_pkg::OFS_BAUD, 32'h40);
        $display("test registers done");
        // three frames back to back, each when the data slot is free
        for (int k = 0; k < 3; k++) begin
            b[k] = 8'($urandom);
            wait_set(ubt_pkg::STAT_DRE);
            exp_q.push_back(b[k]);
            apb(1'b1, ubt_pkg::OFS_TX_LOW, {24'h0, b[k]});
        end
        wait_set(ubt_pkg::STAT_TXC);
        apb(1'b1, ubt_pkg::OFS_STATUS, 32'h40);
        // 5-bit character: upper bits dropped, peer sees idle high there
        apb(1'b1, ubt_pkg::OFS_FRAME, 32'h0);
        exp_q.push_back(b[0] | 8'he0);
        apb(1'b1, ubt_pkg::OFS_TX_LOW, {24'h0, b[0]});
        wait_set(ubt_pkg::STAT_TXC);
        apb(1'b1, ubt_pkg::OFS_FRAME, 32'h3);
        $display("test transmit done");
        // third frame into a full buffer overwrites and is flagged
        for (int k = 0; k < 3; k++) begin
            b[k] = 8'($urandom);
            ubt_remote_i.send(b[k], 1'b1);
        end
        rdchk(ubt_pkg::OFS_RX_HIGH, 32'h80);
        rdchk(ubt_pkg::OFS_RX_LOW, {24'h0, b[0]});
        rdchk(ubt_pkg::OFS_RX_HIGH, 32'hc0);
        rdchk(ubt_pkg::OFS_RX_LOW, {24'h0, b[2]});
        rdchk(ubt_pkg::OFS_RX_HIGH, 32'h0);
        ubt_remote_i.send(b[1], 1'b0);
        rdchk(ubt_pkg::OFS_RX_HIGH, 32'h84);
        rdchk(ubt_pkg::OFS_RX_LOW, {24'h0, b[1]});
        ubt_remote_i.send(b[2], 1'b1);
        apb(1'b1, ubt_pkg::OFS_CTRL, 32'h2);
        apb(1'b1, ubt_pkg::OFS_CTRL, 32'h3);
        apb(1'b0, ubt_pkg::OFS_STATUS, 32'h0);
        check("receive flag", 32'h0, {31'h0, rd[7]});
        $display("test receive done");
        // disable with a frame pending: it still goes out, then pin released
        exp_q.push_back(b[1]);
        apb(1'b1, ubt_pkg::OFS_TX_LOW, {24'h0, b[1]});
        apb(1'b1, ubt_pkg::OFS_CTRL, 32'h1);
        check("pin driven", 32'h0, {31'h0, txd_oe_n});
        repeat (200) @(posedge pclk);
        check("pin released", 32'h1, {31'h0, txd_oe_n});
        check("pending frames", 32'h0, exp_q.size());
        $display("test disable done");
        results();
    end
endmodule
